/* File: src/mhp_params.svh */
// Purpose: Offsets, field positions, reset values and limits of the MAC header parser
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef MHP_PARAMS_SVH
`define MHP_PARAMS_SVH
// ********************
// Register offsets
// ********************
`define MHP_REG_CTRL 8'h00
`define MHP_REG_PANSHORT 8'h04
`define MHP_REG_EUI_LO 8'h08
`define MHP_REG_EUI_HI 8'h0C
`define MHP_REG_STATUS 8'h10
`define MHP_REG_DSTPAN 8'h14
`define MHP_REG_DADDR_LO 8'h18
`define MHP_REG_DADDR_HI 8'h1C
`define MHP_REG_LENGTHS 8'h20
`define MHP_REG_TRAILER 8'h24
// ********************
// Control and status fields, reset values
// ********************
`define MHP_CTRL_LONG 0
`define MHP_CTRL_FILT 1
`define MHP_CTRL_HOLD 2
`define MHP_CTRL_VER_LSB 4
`define MHP_CTRL_RST 32'h0000_0032
`define MHP_ST_DONE 0
`define MHP_ST_ACC 1
`define MHP_ST_LENERR 2
`define MHP_ST_RESERR 3
`define MHP_ST_VERERR 4
`define MHP_RESP_OK 2'h0
`define MHP_RESP_SLV 2'h2
// ********************
// Frame limits
// ********************
`define MHP_MAX_STD 10'h07F
`define MHP_MAX_LONG 10'h3FF
`define MHP_FCS_LEN 10'h002
`define MHP_SEQ_POS 10'h002
`define MHP_BCAST 16'hFFFF
`define MHP_FIFO_DEPTH 8
`endif

/* File: src/mhp_parser.sv */
// Purpose: Receive-side MAC header parser with destination filtering and AXI4-Lite registers
// Assumes: Octets arrive in order on clk_sys; rxLast marks the final (FCS) octet
// Notes: An 8-deep FIFO buffers the octet stream; the parser stalls in hold mode
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`include "mhp_params.svh"

// ********************
// Octet FIFO
// ********************
module mhp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_q, rdPtr_q;
   logic [AW:0] cnt_q, cnt_d;
   wire push = inValid & inReady;
   wire pop = outValid & outReady;
   // Ready is registered so the source sees a clean flop
   assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   assign outValid = cnt_q != '0;
   assign outData = mem[rdPtr_q];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         cnt_q <= '0;
         inReady <= 1'b1;
      end else begin
         wrPtr_q <= push ? AW'((wrPtr_q + 1'b1) % DEPTH) : wrPtr_q;
         rdPtr_q <= pop ? AW'((rdPtr_q + 1'b1) % DEPTH) : rdPtr_q;
         cnt_q <= cnt_d;
         inReady <= cnt_d != (AW+1)'(DEPTH);
      end
   end
   // Storage has no reset; only written entries are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end
endmodule : mhp_fifo

module mhp_parser (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   input wire logic rxLast,
   output logic rxReady,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic fltValid,
   output logic fltAccept,
   output logic [1:0] fltDstMode,
   output logic [15:0] fltDstPan,
   output logic [63:0] fltDstAddr
);
   // ********************
   // Declarations
   // ********************
   mhp_pkg::mhp_state_type state_q;
   mhp_pkg::mhp_oct_type oct;
   mhp_pkg::mhp_fc_type fc;
   logic octValid, popRdy;
   logic [15:0] fcWord_q, dstPan_q, fcs_q;
   logic [63:0] dstAddr_q;
   logic [9:0] idx_q, hdrLen_q, frameLen_q, payLen_q;
   logic [7:0] seq_q;
   logic [31:0] ctrl_q, panShort_q, euiLo_q, euiHi_q, rdMux;
   logic [4:0] stat_q, statSet;
   logic awHave_q, wHave_q;
   logic [7:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;

   mhp_fifo #(.WIDTH(9), .DEPTH(`MHP_FIFO_DEPTH)) u_fifo (
      .clk(clk_sys),
      .rst(sys_rst),
      .inValid(rxValid),
      .inData({rxLast, rxData}),
      .inReady(rxReady),
      .outValid(octValid),
      .outData(oct),
      .outReady(popRdy)
   );

   // ********************
   // Header field decode
   // ********************
   // Field lengths follow from frame control alone, except the aux header
   assign fc = mhp_pkg::mhp_fc_type'(fcWord_q);
   wire dstPres = fc.dstMode[1];
   wire srcPres = fc.srcMode[1];
   wire [9:0] dPanLen = dstPres ? 10'h002 : 10'h000;
   wire [9:0] dAdrLen = !dstPres ? 10'h000 : (fc.dstMode[0] ? 10'h008 : 10'h002);
   wire [9:0] sPanLen = (srcPres && !(fc.panComp && dstPres)) ? 10'h002 : 10'h000;
   wire [9:0] sAdrLen = !srcPres ? 10'h000 : (fc.srcMode[0] ? 10'h008 : 10'h002);
   wire [9:0] dAdrPos = `MHP_SEQ_POS + 10'h001 + dPanLen;
   wire [9:0] auxPos = dAdrPos + dAdrLen + sPanLen + sAdrLen;
   // Aux header length from the key identifier mode of its first octet
   wire [1:0] keyMode = oct.data[4:3];
   wire [9:0] auxLen = (keyMode == 2'h0) ? 10'h005 : (keyMode == 2'h1) ? 10'h006 :
                       (keyMode == 2'h2) ? 10'h00A : 10'h00E;
   wire [9:0] maxLen = ctrl_q[`MHP_CTRL_LONG] ? `MHP_MAX_LONG : `MHP_MAX_STD;
   wire take = octValid & popRdy;
   wire [9:0] lenNow = idx_q + 10'h001;
   wire [9:0] dAdrOff = idx_q - dAdrPos;
   wire [3:0] verMask = ctrl_q[`MHP_CTRL_VER_LSB +: 4];

   // ********************
   // Filter decision at the final octet
   // ********************
   wire lenBad = (lenNow < hdrLen_q + `MHP_FCS_LEN) || (lenNow > maxLen);
   wire resBad = fc.ftype[2] || (fc.dstMode == 2'h1) || (fc.srcMode == 2'h1);
   wire verBad = !verMask[fc.version];
   wire panOk = (dstPan_q == panShort_q[15:0]) || (dstPan_q == `MHP_BCAST);
   wire shortOk = (dstAddr_q[15:0] == panShort_q[31:16]) || (dstAddr_q[15:0] == `MHP_BCAST);
   wire longOk = dstAddr_q == {euiHi_q, euiLo_q};
   wire addrOk = !dstPres || (panOk && (fc.dstMode[0] ? longOk : shortOk));
   wire filtOn = ctrl_q[`MHP_CTRL_FILT];
   wire accept = !lenBad && (!filtOn || (!resBad && !verBad && addrOk));
   wire endNow = take && oct.last;
   assign popRdy = state_q != mhp_pkg::ST_HOLD;
   assign statSet = endNow ? {verBad & filtOn, resBad, lenBad, accept, 1'b1} : 5'h00;

   // Frame control low octet first, then everything else only after it
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         fcWord_q <= 16'h0000;
         seq_q <= 8'h00;
         dstPan_q <= 16'h0000;
         dstAddr_q <= 64'h0;
      end else if (take && state_q == mhp_pkg::ST_RUN) begin
         if (idx_q == 10'h000) begin
            fcWord_q[7:0] <= oct.data;
            dstPan_q <= 16'h0000;
            dstAddr_q <= 64'h0;
         end
         if (idx_q == 10'h001) begin
            fcWord_q[15:8] <= oct.data;
         end
         if (idx_q == `MHP_SEQ_POS) begin
            seq_q <= oct.data;
         end
         if (idx_q > `MHP_SEQ_POS && idx_q < dAdrPos) begin
            dstPan_q[{idx_q[0] ^ 1'b1, 3'b000} +: 8] <= oct.data;
         end
         if (idx_q >= dAdrPos && idx_q < dAdrPos + dAdrLen) begin
            dstAddr_q[{dAdrOff[2:0], 3'b000} +: 8] <= oct.data;
         end
      end
   end

   // Sequencing: header length, overlong drop and optional hold
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= mhp_pkg::ST_RUN;
         idx_q <= 10'h000;
         hdrLen_q <= 10'h000;
      end else begin
         case (state_q)
            mhp_pkg::ST_RUN: begin
               if (take) begin
                  idx_q <= oct.last ? 10'h000 : lenNow;
                  if (idx_q == `MHP_SEQ_POS) begin
                     hdrLen_q <= auxPos;
                  end else if (fc.secEn && idx_q == auxPos && idx_q > `MHP_SEQ_POS) begin
                     hdrLen_q <= auxPos + auxLen;
                  end
                  if (endNow && ctrl_q[`MHP_CTRL_HOLD]) begin
                     state_q <= mhp_pkg::ST_HOLD;
                  end else if (!oct.last && lenNow == maxLen) begin
                     state_q <= mhp_pkg::ST_DROP;
                  end
               end
            end
            mhp_pkg::ST_DROP: begin
               if (endNow) begin
                  idx_q <= 10'h000;
                  state_q <= ctrl_q[`MHP_CTRL_HOLD] ? mhp_pkg::ST_HOLD : mhp_pkg::ST_RUN;
               end
            end
            mhp_pkg::ST_HOLD: begin
               if (!stat_q[`MHP_ST_DONE]) begin
                  state_q <= mhp_pkg::ST_RUN;
               end
            end
            default: begin
               state_q <= mhp_pkg::ST_RUN;
            end
         endcase
      end
   end

   // Frame results; FCS is the last two octets, payload what lies between
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         fcs_q <= 16'h0000;
         frameLen_q <= 10'h000;
         payLen_q <= 10'h000;
         fltValid <= 1'b0;
         fltAccept <= 1'b0;
         fltDstMode <= 2'h0;
         fltDstPan <= 16'h0000;
         fltDstAddr <= 64'h0;
      end else begin
         fltValid <= endNow;
         if (take) begin
            fcs_q <= {oct.data, fcs_q[15:8]};
         end
         if (endNow) begin
            frameLen_q <= (state_q == mhp_pkg::ST_DROP) ? maxLen : lenNow;
            payLen_q <= lenBad ? 10'h000 : lenNow - hdrLen_q - `MHP_FCS_LEN;
            fltAccept <= accept && state_q == mhp_pkg::ST_RUN;
            fltDstMode <= fc.dstMode;
            fltDstPan <= dstPan_q;
            fltDstAddr <= dstAddr_q;
         end
      end
   end

   // ********************
   // AXI4-Lite slave
   // ********************
   // Byte-lane merge for writable registers
   function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction : mergeBytes

   wire doWrite = awHave_q & wHave_q & ~s_axi_bvalid;
   wire wrCtrl = doWrite && awAddr_q == `MHP_REG_CTRL;
   wire wrPan = doWrite && awAddr_q == `MHP_REG_PANSHORT;
   wire wrEuiLo = doWrite && awAddr_q == `MHP_REG_EUI_LO;
   wire wrEuiHi = doWrite && awAddr_q == `MHP_REG_EUI_HI;
   wire wrStat = doWrite && awAddr_q == `MHP_REG_STATUS && wStrb_q[0];
   wire wrMapped = wrCtrl | wrPan | wrEuiLo | wrEuiHi | (doWrite && awAddr_q == `MHP_REG_STATUS);
   wire [4:0] statClr = wrStat ? wData_q[4:0] : 5'h00;
   wire rdTake = s_axi_arvalid & s_axi_arready;
   wire rdHit = s_axi_araddr <= `MHP_REG_TRAILER && s_axi_araddr[1:0] == 2'h0;
   // Read select; unmapped offsets return zero with a slave error
   assign rdMux = (s_axi_araddr == `MHP_REG_CTRL) ? ctrl_q :
                  (s_axi_araddr == `MHP_REG_PANSHORT) ? panShort_q :
                  (s_axi_araddr == `MHP_REG_EUI_LO) ? euiLo_q :
                  (s_axi_araddr == `MHP_REG_EUI_HI) ? euiHi_q :
                  (s_axi_araddr == `MHP_REG_STATUS) ? {fcWord_q, 11'h000, stat_q} :
                  (s_axi_araddr == `MHP_REG_DSTPAN) ? {14'h0000, fc.dstMode, dstPan_q} :
                  (s_axi_araddr == `MHP_REG_DADDR_LO) ? dstAddr_q[31:0] :
                  (s_axi_araddr == `MHP_REG_DADDR_HI) ? dstAddr_q[63:32] :
                  (s_axi_araddr == `MHP_REG_LENGTHS) ? {6'h00, payLen_q, 6'h00, frameLen_q} :
                  (s_axi_araddr == `MHP_REG_TRAILER) ? {8'h00, seq_q, fcs_q} : 32'h0000_0000;

   // Write channel: address and data taken in either order, one write at a time
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q <= 32'h0000_0000;
         wStrb_q <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `MHP_RESP_OK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (doWrite) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? `MHP_RESP_OK : `MHP_RESP_SLV;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Registers; a status event in the clearing cycle stays set
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= `MHP_CTRL_RST;
         panShort_q <= 32'h0000_0000;
         euiLo_q <= 32'h0000_0000;
         euiHi_q <= 32'h0000_0000;
         stat_q <= 5'h00;
      end else begin
         ctrl_q <= wrCtrl ? (mergeBytes(ctrl_q, wData_q, wStrb_q) & 32'h0000_00F7) : ctrl_q;
         panShort_q <= wrPan ? mergeBytes(panShort_q, wData_q, wStrb_q) : panShort_q;
         euiLo_q <= wrEuiLo ? mergeBytes(euiLo_q, wData_q, wStrb_q) : euiLo_q;
         euiHi_q <= wrEuiHi ? mergeBytes(euiHi_q, wData_q, wStrb_q) : euiHi_q;
         stat_q <= (stat_q & ~statClr) | statSet;
      end
   end

   // Read channel: answer one cycle after the address is taken
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `MHP_RESP_OK;
      end else if (rdTake) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdMux;
         s_axi_rresp <= rdHit ? `MHP_RESP_OK : `MHP_RESP_SLV;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ********************
   // Checks
   // ********************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   chk_fc_low_first: assert property (
      take && state_q == mhp_pkg::ST_RUN && idx_q == 10'h000 |=> fcWord_q[7:0] == $past(oct.data))
      else $error("frame control low octet not first");
   chk_fc_before_seq: assert property (
      take && state_q == mhp_pkg::ST_RUN && idx_q == `MHP_SEQ_POS |-> $past(idx_q) == 10'h001 || !$past(take))
      else $error("sequence octet reached before frame control complete");
   chk_hdr_range: assert property (
      take && state_q == mhp_pkg::ST_RUN && idx_q == `MHP_SEQ_POS |=> hdrLen_q >= 10'h003 && hdrLen_q <= 10'h017)
      else $error("header length out of range");
   chk_payload_sum: assert property (
      fltValid && !stat_q[`MHP_ST_LENERR] |-> payLen_q + hdrLen_q + `MHP_FCS_LEN == frameLen_q)
      else $error("payload length does not close the frame");
   chk_len_limit: assert property (
      fltValid && fltAccept |-> frameLen_q <= (ctrl_q[`MHP_CTRL_LONG] ? `MHP_MAX_LONG : `MHP_MAX_STD))
      else $error("accepted frame over length limit");
   chk_type_reserved: assert property (
      fltValid && fltAccept && ctrl_q[`MHP_CTRL_FILT] |-> fcWord_q[2] == 1'b0)
      else $error("reserved frame type accepted");
   chk_version_reject: assert property (
      fltValid && ctrl_q[`MHP_CTRL_FILT] && !verMask[fcWord_q[13:12]] |-> !fltAccept)
      else $error("bad frame version accepted");
   chk_short_match: assert property (
      fltValid && fltAccept && ctrl_q[`MHP_CTRL_FILT] && fltDstMode == 2'h2 |->
      (fltDstPan == panShort_q[15:0] || fltDstPan == `MHP_BCAST))
      else $error("short address frame accepted with foreign PAN");
   chk_hold_stall: assert property (
      state_q == mhp_pkg::ST_HOLD && stat_q[`MHP_ST_DONE] |=> state_q == mhp_pkg::ST_HOLD && !popRdy)
      else $error("parser left hold without acknowledge");
   cov_accept: cover property (fltValid && fltAccept && fltDstMode == 2'h3);
   cov_long: cover property (fltValid && frameLen_q > `MHP_MAX_STD);
   cov_fifo_full: cover property (!rxReady ##1 rxReady);
endmodule : mhp_parser

/* File: src/mhp_pkg.sv */
// Purpose: Types shared by the MAC header parser
// Assumes: Constants live in mhp_params.svh
// Notes: Frame control struct is laid out so bit 0 of the word is the type LSB
package mhp_pkg;
   // Frame control word, MSB first
   typedef struct packed {
      logic [1:0] srcMode;
      logic [1:0] version;
      logic [1:0] dstMode;
      logic [2:0] resv;
      logic panComp;
      logic ackReq;
      logic pending;
      logic secEn;
      logic [2:0] ftype;
   } mhp_fc_type;
   // One octet of the receive stream
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } mhp_oct_type;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_DROP = 2'b01,
      ST_HOLD = 2'b10
   } mhp_state_type;
endpackage : mhp_pkg

/* File: verification/mhp_parser_tb.sv */
// Purpose: Self-checking bench for the MAC header parser
// Assumes: Registers over AXI4-Lite, octets from mhp_phy_src
// Notes: Expected results come from a behavioural header decoder
`timescale 1ns/10ps
`include "mhp_params.svh"
module mhp_parser_tb;
   localparam logic [15:0] OWN_PAN = 16'hABCD;
   localparam logic [15:0] OWN_SHORT = 16'h1234;
   localparam logic [63:0] OWN_EUI = 64'h0102_0304_0506_0708;
   logic clk_sys = 1'h0;
   logic sys_rst = 1'h1;
   logic rxValid, rxLast, rxReady, fltValid, fltAccept;
   logic [7:0] rxData, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, ctrl = `MHP_CTRL_RST, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, fltDstMode, r;
   logic [15:0] fltDstPan;
   logic [63:0] fltDstAddr;
   logic [82:0] seen;
   logic got = 1'h0;
   int failures = 0, cmp_count = 0, cycles = 0;
   int tab[15][3] = '{'{16'h8861, 0, 5}, '{16'h8841, 1, 0}, '{16'h9C41, 0, 3}, '{16'h8841, 2, 2},
      '{16'hC000, 0, 4}, '{16'h8441, 0, 2}, '{16'hA841, 0, 2}, '{16'hC81B, 0, 6}, '{16'h0002, 0, 0},
      '{16'h4841, 0, 1}, '{16'h8841, 0, -1}, '{16'h8841, 0, 116}, '{16'h8841, 0, 117}, '{16'h9C41, 1, 1},
      '{16'hC80B, 0, 9}};
   mhp_parser u_mhp_parser (.clk_sys, .sys_rst, .rxValid, .rxData, .rxLast, .rxReady, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .fltValid, .fltAccept, .fltDstMode, .fltDstPan, .fltDstAddr);
   mhp_phy_src u_mhp_phy_src (.clk_sys, .rxValid, .rxData, .rxLast, .rxReady);
   always #12.5 clk_sys = ~clk_sys;
   // Capture each frame result; the cycle ceiling cuts a hang short
   always @(posedge clk_sys) begin
      cycles++;
      if (fltValid === 1'h1) begin
         seen <= {fltAccept, fltDstMode, fltDstPan, fltDstAddr};
         got <= 1'h1;
      end
      if (cycles == 60000) begin
         failures++;
         give_verdict();
      end
   end
   task automatic check(input string what, input logic [127:0] exp, input logic [127:0] act);
      cmp_count++;
      if (exp !== act) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, act);
      end
   endtask : check
   task automatic give_verdict();
      if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   // Bus cycles: each channel released only at its own handshake edge
   task automatic axw(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] resp);
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
         if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      resp = s_axi_bresp;
      // Ready stays high between calls, so back-to-back writes never drive it twice in one step
   endtask : axw
   task automatic axr(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] resp);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      // Ready stays high between calls, so back-to-back reads never drive it twice in one step
   endtask : axr
   // Build a frame, decode it behaviourally, send it and compare accept and status; destination, lengths and trailer only for frames of valid length
   task automatic run(input logic [15:0] fc, input int kind, input int pl);
      logic [7:0] p[$], f[$];
      logic [63:0] da, adr;
      logic [15:0] pan;
      logic [31:0] rd;
      logic [1:0] rs;
      logic ok, vE, rE, acc;
      int n, dl, sl, tot;
      for (int i = 0; i < 40; i++) p.push_back(8'($urandom));
      {p[1], p[0]} = fc;
      da = kind == 2 ? 64'hFFFF_FFFF_FFFF_FFFF : fc[10] ? OWN_EUI : 64'(OWN_SHORT);
      if (kind != 1) begin
         {p[4], p[3]} = kind == 2 ? 16'hFFFF : OWN_PAN;
         for (int i = 0; i < 8; i++) p[5 + i] = da[8 * i +: 8];
      end
      dl = fc[11] ? (fc[10] ? 8 : 2) : 0;
      sl = fc[15] ? (fc[14] ? 8 : 2) : 0;
      pan = dl != 0 ? {p[4], p[3]} : 16'h0000;
      adr = 64'h0;
      for (int i = 0; i < dl; i++) adr[8 * i +: 8] = p[5 + i];
      n = 3 + dl + (dl != 0 ? 2 : 0) + sl + (sl != 0 && !(fc[6] && dl != 0) ? 2 : 0);
      if (fc[3]) n += p[n][4] ? (p[n][3] ? 14 : 10) : (p[n][3] ? 6 : 5);
      tot = n + 2 + pl;
      ok = tot <= (ctrl[0] ? 1023 : 127) && tot >= n + 2;
      vE = ctrl[1] && !ctrl[4 + fc[13:12]];
      rE = fc[2:0] > 3 || fc[11:10] == 1 || fc[15:14] == 1;
      acc = ok && !vE && !(ctrl[1] && rE) && !(ctrl[1] && dl != 0 && !((pan == OWN_PAN || pan == 16'hFFFF)
         && (dl == 8 ? adr == OWN_EUI : adr[15:0] == OWN_SHORT || adr[15:0] == 16'hFFFF)));
      f = p[0 : (tot < n ? tot : n) - 1];
      while (f.size() < tot) f.push_back(8'($urandom));
      got = 1'h0;
      u_mhp_phy_src.send(f);
      for (int i = 0; i < 3000 && got !== 1'h1; i++) @(posedge clk_sys);
      check("frame done", 1'h1, got);
      check("accept", acc, seen[82]);
      if (ok && fc[11:10] != 1) check("dest", {fc[11:10], pan, adr}, seen[81:0]);
      axr(`MHP_REG_STATUS, rd, rs);
      if (ok) check("status", {fc, 11'h000, vE, rE, 1'h0, acc, 1'h1}, rd);
      else check("status", 3'h5, rd[2:0]);
      if (ok) begin
         axr(`MHP_REG_LENGTHS, rd, rs);
         check("lengths", {6'h00, 10'(pl), 6'h00, 10'(tot)}, rd);
         axr(`MHP_REG_TRAILER, rd, rs);
         check("trailer", {f[2], f[tot - 1], f[tot - 2]}, rd[23:0]);
      end
      if (!ctrl[2]) axw(`MHP_REG_STATUS, 32'h0000_001F, rs);
   endtask : run
   // ****************
   // Main sequence
   // ****************
   initial begin
      void'($urandom(94));
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'h0;
      @(posedge clk_sys);
      axr(`MHP_REG_CTRL, d, r);
      check("ctrl reset", `MHP_CTRL_RST, d);
      axw(`MHP_REG_PANSHORT, {OWN_SHORT, OWN_PAN}, r);
      axw(`MHP_REG_EUI_LO, OWN_EUI[31:0], r);
      axw(`MHP_REG_EUI_HI, OWN_EUI[63:32], r);
      axr(`MHP_REG_EUI_HI, d, r);
      check("eui", OWN_EUI[63:32], d);
      axw(`MHP_REG_LENGTHS, 32'h0, r);
      check("ro write", `MHP_RESP_SLV, r);
      axr(8'h28, d, r);
      check("unmapped read", {`MHP_RESP_SLV, 32'h0}, {r, d});
      for (int t = 0; t < 8; t++) run(16'h8840 | 16'(t), 0, t);
      for (int i = 0; i < 15; i++) run(16'(tab[i][0]), tab[i][1], tab[i][2]);
      ctrl = 32'h0000_0033;
      axw(`MHP_REG_CTRL, ctrl, r);
      run(16'h8841, 0, 1012);
      run(16'h8841, 0, 1013);
      ctrl = 32'h0000_0034;
      axw(`MHP_REG_CTRL, ctrl, r);
      run(16'hA841, 1, 0);
      fork
         run(16'h0002, 0, 12);
      join_none
      repeat (40) @(posedge clk_sys);
      check("ready while held", 1'h0, rxReady);
      axw(`MHP_REG_STATUS, 32'h0000_001F, r);
      wait fork;
      give_verdict();
   end
endmodule : mhp_parser_tb

/* File: verification/mhp_phy_src.sv */
// Purpose: Receive path model that feeds octets to the parser
// Assumes: Frames are handed over as octet queues
// Notes: Pacing is random; idle data lines show the inverse of the last octet
`timescale 1ns/10ps
module mhp_phy_src (
   input wire logic clk_sys,
   output logic rxValid,
   output logic [7:0] rxData,
   output logic rxLast,
   input wire logic rxReady
);
   initial begin
      rxValid = 1'h0;
      rxData = 8'h00;
      rxLast = 1'h0;
   end
   // Octets leave in frame order, each held until the parser takes it
   task automatic send(input logic [7:0] f[$]);
      for (int i = 0; i < f.size(); i++) begin
         rxValid <= 1'h1;
         rxData <= f[i];
         rxLast <= (i == f.size() - 1);
         do @(posedge clk_sys); while (rxReady !== 1'h1);
         if ($urandom % 4 == 0) begin
            rxValid <= 1'h0;
            rxData <= ~f[i]; // Stale octet must not look valid
            @(posedge clk_sys);
         end
      end
      rxValid <= 1'h0;
      rxLast <= 1'h0;
      rxData <= ~f[f.size() - 1];
   endtask : send
endmodule : mhp_phy_src
